// [src/srr_regs.vh]
// Constants for the status reporting register bank.
// Assumes inclusion by the status bank under src/ and by its checker and bench under sim/.
`ifndef SRR_REGS_VH
`define SRR_REGS_VH

// ----------------------------------------------------------------
// Command codes on the host command port
// ----------------------------------------------------------------
`define SRR_CMD_W            3
`define SRR_CMD_OPER_COND    3'h0
`define SRR_CMD_OPER_EVENT   3'h1
`define SRR_CMD_OPER_ENAB_RD 3'h2
`define SRR_CMD_OPER_ENAB_WR 3'h3
`define SRR_CMD_QUES_COND    3'h4
`define SRR_CMD_QUES_EVENT   3'h5
`define SRR_CMD_QUES_ENAB_RD 3'h6
`define SRR_CMD_QUES_ENAB_WR 3'h7

// ----------------------------------------------------------------
// Operation group bit positions
// ----------------------------------------------------------------
`define SRR_OP_TRIG_WAIT   5
`define SRR_OP_TRAN_PRIMED 6
`define SRR_OP_CONST_VOLT  8
`define SRR_OP_TRAN_DONE   9
`define SRR_OP_CONST_CURR  10
`define SRR_OP_SAMPLE_DONE 11
`define SRR_OP_LIST_DONE   12
`define SRR_OP_LIST_ACTIVE 14
`define SRR_OP_USED_MASK   16'h5F60

// ----------------------------------------------------------------
// Questionable group bit positions
// ----------------------------------------------------------------
`define SRR_QU_VREG_FAULT  0
`define SRR_QU_CREG_FAULT  1
`define SRR_QU_THERMAL     3
`define SRR_QU_FOLLOWER    6
`define SRR_QU_VOLT_FAULT  12
`define SRR_QU_CURR_FAULT  13
`define SRR_QU_ABSORB      14
`define SRR_QU_USED_MASK   16'h704B
`define SRR_QU_LATCH_MASK  16'h3000

// ----------------------------------------------------------------
// Preset and reset values, status byte positions
// ----------------------------------------------------------------
`define SRR_OPER_PRESET    16'h2001
`define SRR_QUES_PRESET    16'h00FF
`define SRR_ENAB_RESET     16'h0000
`define SRR_SB_QUES_BIT    3
`define SRR_SB_OPER_BIT    7

`endif

// [src/srr_edge_latch.v]
// Rising-edge event latch with read-clear for one register group.
// Assumes condition inputs on clk_in; clear comes from a host read.
`timescale 1ns/1ps

module srr_edge_latch
#(
  parameter WIDTH = 16
)
(
  // Clock and reset
  input  wire             clk_in,
  input  wire             srst_in,
  // Condition and control
  input  wire [WIDTH-1:0] cond_in,
  input  wire [WIDTH-1:0] latch_mask_in,
  input  wire             clear_in,
  // Latched events
  output wire [WIDTH-1:0] event_out
);

  reg  [WIDTH-1:0] cond_prev_ff;
  reg  [WIDTH-1:0] event_ff;
  wire [WIDTH-1:0] rise;
  wire [WIDTH-1:0] nxt_event;

  // Inactive to active transitions of latchable bits
  assign rise = cond_in & ~cond_prev_ff & latch_mask_in;
  // Set wins over the read clear, so no event is lost
  assign nxt_event = (clear_in ? {WIDTH{1'b0}} : event_ff) | rise;
  assign event_out = event_ff;

  // Edge history and event register
  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      cond_prev_ff <= {WIDTH{1'b0}};
      event_ff     <= {WIDTH{1'b0}};
    end
    else
    begin
      cond_prev_ff <= cond_in;
      event_ff     <= nxt_event;
    end
  end

endmodule

// [src/srr_sync.v]
// Two-flop synchroniser for a bus of independent level signals.
// Assumes each bit is a slow level; no word coherence is given.
`timescale 1ns/1ps

module srr_sync
#(
  parameter WIDTH = 16
)
(
  // Clock and reset
  input  wire             clk_in,
  input  wire             srst_in,
  // Asynchronous levels
  input  wire [WIDTH-1:0] async_in,
  // Synchronised levels
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  assign sync_out = sync_ff;

  // First stage feeds only the second stage
  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

endmodule

// [src/srr_status_regs.v]
// Operation and questionable status register groups with summaries.
// Assumes status levels arrive from analog/firmware logic outside the
// clock domain, and the command port is driven on clk_in.
//
// How it works
// - Operation bits: CC 10, CV 8, LR 14, LC 12, SC 11, TC 9, TA 6, TRIGGER_WAIT_FLAG 5.
// - Operation condition register shows live state, never latched.
// - Operation enable masks events onto status byte bit 7.
// - Operation summary is OR of enabled operation event bits.
// - Operation event register is read-only and holds events until read.
// - Reading operation events returns value then clears all bits except those rising in that cycle.
// - Operation enable reads back last written mask unchanged.
// - Preset loads operation enable 8193 and questionable enable 255.
// - Questionable bits: energy_absorb_flag 14, CE 13, VE 12, SE 6, TE 3, CM 1, VM 0.
// - Questionable events latch only bits 13 and 12.
// - Bits 0 and 1 are never latched as questionable events.
// - Reading questionable events returns value then clears it.
// - Questionable condition register shows live condition state.
// - Bits 1 and 0 may both be set while output settles.
// - Questionable enable masks events onto status byte bit 3.
// - Questionable summary is OR of enabled questionable event bits.
// - Questionable enable reads back current mask.
`timescale 1ns/1ps
`include "srr_regs.vh"

module srr_status_regs
#(
  parameter WIDTH = 16
)
(
  // Clock and reset
  input  wire                    clk_in,
  input  wire                    srst_in,
  // Operation status levels
  input  wire                    constant_current_flag_in,
  input  wire                    constant_voltage_flag_in,
  input  wire                    list_active_flag_in,
  input  wire                    list_done_flag_in,
  input  wire                    sample_done_flag_in,
  input  wire                    transient_done_flag_in,
  input  wire                    transient_primed_flag_in,
  input  wire                    trigger_wait_flag_in,
  // Questionable status levels
  input  wire                    energy_absorb_flag_in,
  input  wire                    current_fault_flag_in,
  input  wire                    voltage_fault_flag_in,
  input  wire                    follower_unit_fault_flag_in,
  input  wire                    thermal_fault_flag_in,
  input  wire                    current_regulation_fault_flag_in,
  input  wire                    voltage_regulation_fault_flag_in,
  // Host command port
  input  wire                    cmd_valid_in,
  input  wire [`SRR_CMD_W-1:0]   cmd_code_in,
  input  wire [WIDTH-1:0]        cmd_wdata_in,
  input  wire                    preset_in,
  // Host answer
  output wire                    rsp_valid_out,
  output wire [WIDTH-1:0]        rsp_data_out,
  // Status byte summaries
  output wire                    oper_summary_out,
  output wire                    ques_summary_out
);

  // ----------------------------------------------------------------
  // Raw vectors and synchronisation
  // ----------------------------------------------------------------
  wire [WIDTH-1:0] oper_raw;
  wire [WIDTH-1:0] ques_raw;
  wire [WIDTH-1:0] operation_live_state;
  wire [WIDTH-1:0] questionable_live_state;

  // Packs one bit at a given position into a zero vector
  function [WIDTH-1:0] place_bit;
    input         val;
    input integer pos;
    begin
      place_bit = {WIDTH{1'b0}};
      place_bit[pos] = val;
    end
  endfunction

  // Operation layout, unused positions left zero
  // operation bit placement
  assign oper_raw = place_bit(constant_current_flag_in, `SRR_OP_CONST_CURR)
                  | place_bit(constant_voltage_flag_in, `SRR_OP_CONST_VOLT)
                  | place_bit(list_active_flag_in, `SRR_OP_LIST_ACTIVE)
                  | place_bit(list_done_flag_in, `SRR_OP_LIST_DONE)
                  | place_bit(sample_done_flag_in, `SRR_OP_SAMPLE_DONE)
                  | place_bit(transient_done_flag_in, `SRR_OP_TRAN_DONE)
                  | place_bit(transient_primed_flag_in, `SRR_OP_TRAN_PRIMED)
                  | place_bit(trigger_wait_flag_in, `SRR_OP_TRIG_WAIT);

  // Questionable layout; settling may raise both regulation bits
  // questionable bit placement
  assign ques_raw = place_bit(energy_absorb_flag_in, `SRR_QU_ABSORB)
                  | place_bit(current_fault_flag_in, `SRR_QU_CURR_FAULT)
                  | place_bit(voltage_fault_flag_in, `SRR_QU_VOLT_FAULT)
                  | place_bit(follower_unit_fault_flag_in, `SRR_QU_FOLLOWER)
                  | place_bit(thermal_fault_flag_in, `SRR_QU_THERMAL)
                  | place_bit(current_regulation_fault_flag_in, `SRR_QU_CREG_FAULT)
                  | place_bit(voltage_regulation_fault_flag_in, `SRR_QU_VREG_FAULT);

  // Status levels come from outside the domain
  // live operation state
  srr_sync #(.WIDTH(WIDTH)) u_oper_sync
  (
    .clk_in   (clk_in),
    .srst_in  (srst_in),
    .async_in (oper_raw),
    .sync_out (operation_live_state)
  );

  srr_sync #(.WIDTH(WIDTH)) u_ques_sync
  (
    .clk_in   (clk_in),
    .srst_in  (srst_in),
    .async_in (ques_raw),
    .sync_out (questionable_live_state)
  );

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire oper_event_rd;
  wire ques_event_rd;
  wire oper_enab_wr;
  wire ques_enab_wr;

  assign oper_event_rd = cmd_valid_in & (cmd_code_in == `SRR_CMD_OPER_EVENT);
  assign ques_event_rd = cmd_valid_in & (cmd_code_in == `SRR_CMD_QUES_EVENT);
  assign oper_enab_wr  = cmd_valid_in & (cmd_code_in == `SRR_CMD_OPER_ENAB_WR);
  assign ques_enab_wr  = cmd_valid_in & (cmd_code_in == `SRR_CMD_QUES_ENAB_WR);

  // ----------------------------------------------------------------
  // Event registers
  // ----------------------------------------------------------------
  wire [WIDTH-1:0] operation_latched_events;
  wire [WIDTH-1:0] questionable_latched_events;

  // Every used operation bit latches on its rising edge
  // edge-set event latch
  srr_edge_latch #(.WIDTH(WIDTH)) u_oper_events
  (
    .clk_in        (clk_in),
    .srst_in       (srst_in),
    .cond_in       (operation_live_state),
    .latch_mask_in (`SRR_OP_USED_MASK),
    .clear_in      (oper_event_rd),
    .event_out     (operation_latched_events)
  );

  // Only current and voltage error bits are latchable
  // latch bits 13 and 12
  srr_edge_latch #(.WIDTH(WIDTH)) u_ques_events
  (
    .clk_in        (clk_in),
    .srst_in       (srst_in),
    .cond_in       (questionable_live_state),
    .latch_mask_in (`SRR_QU_LATCH_MASK),
    .clear_in      (ques_event_rd),
    .event_out     (questionable_latched_events)
  );

  // ----------------------------------------------------------------
  // Enable registers
  // ----------------------------------------------------------------
  reg  [WIDTH-1:0] operation_report_mask_ff;
  reg  [WIDTH-1:0] questionable_report_mask_ff;
  reg  [WIDTH-1:0] nxt_operation_report_mask;
  reg  [WIDTH-1:0] nxt_questionable_report_mask;

  // Preset takes priority over a write in the same cycle
  // preset mask values
  always @*
  begin
    nxt_operation_report_mask    = operation_report_mask_ff;
    nxt_questionable_report_mask = questionable_report_mask_ff;
    if (preset_in)
    begin
      nxt_operation_report_mask    = `SRR_OPER_PRESET;
      nxt_questionable_report_mask = `SRR_QUES_PRESET;
    end
    else
    begin
      if (oper_enab_wr)
        nxt_operation_report_mask = cmd_wdata_in;
      if (ques_enab_wr)
        nxt_questionable_report_mask = cmd_wdata_in;
    end
  end

  // Masks store all bits so readback matches what was written
  // operation mask readback
  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      operation_report_mask_ff    <= `SRR_ENAB_RESET;
      questionable_report_mask_ff <= `SRR_ENAB_RESET;
    end
    else
    begin
      operation_report_mask_ff    <= nxt_operation_report_mask;
      questionable_report_mask_ff <= nxt_questionable_report_mask;
    end
  end

  // ----------------------------------------------------------------
  // Summaries for the status byte
  // ----------------------------------------------------------------
  reg oper_summary_ff;
  reg ques_summary_ff;

  // Unused event bits are always zero, so unused mask bits are inert
  // operation OR of enabled events
  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      oper_summary_ff <= 1'b0;
      ques_summary_ff <= 1'b0;
    end
    else
    begin
      oper_summary_ff <= |(operation_latched_events & operation_report_mask_ff
                           & `SRR_OP_USED_MASK);
      ques_summary_ff <= |(questionable_latched_events & questionable_report_mask_ff
                           & `SRR_QU_USED_MASK);
    end
  end

  assign oper_summary_out = oper_summary_ff;
  assign ques_summary_out = ques_summary_ff;

  // ----------------------------------------------------------------
  // Read answer path
  // ----------------------------------------------------------------
  reg              rsp_valid_ff;
  reg  [WIDTH-1:0] rsp_data_ff;
  reg  [WIDTH-1:0] nxt_rsp_data;
  reg              nxt_rsp_valid;

  // Event reads capture the value before the clear takes effect
  // unused bits read zero except on enable reads
  always @*
  begin
    nxt_rsp_valid = 1'b0;
    nxt_rsp_data  = rsp_data_ff;
    if (cmd_valid_in)
    begin
      case (cmd_code_in)
        `SRR_CMD_OPER_COND:
        begin
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data  = operation_live_state & `SRR_OP_USED_MASK;
        end
        `SRR_CMD_OPER_EVENT:
        begin
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data  = operation_latched_events;
        end
        `SRR_CMD_OPER_ENAB_RD:
        begin
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data  = operation_report_mask_ff;
        end
        `SRR_CMD_QUES_COND:
        begin
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data  = questionable_live_state & `SRR_QU_USED_MASK;
        end
        `SRR_CMD_QUES_EVENT:
        begin
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data  = questionable_latched_events;
        end
        `SRR_CMD_QUES_ENAB_RD:
        begin
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data  = questionable_report_mask_ff;
        end
        default:
        begin
          nxt_rsp_valid = 1'b0; // Writes give no answer
          nxt_rsp_data  = rsp_data_ff;
        end
      endcase
    end
  end

  // Answer registered one cycle after the command
  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff  <= {WIDTH{1'b0}};
    end
    else
    begin
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_data_ff  <= nxt_rsp_data;
    end
  end

  assign rsp_valid_out = rsp_valid_ff;
  assign rsp_data_out  = rsp_data_ff;

endmodule

// [sim/srr_status_regs_asserts.sv]
// Checker for the status register bank: command answers and masks.
// Assumes it is bound onto srr_status_regs and sees only its ports.
`timescale 1ns/1ps
`include "srr_regs.vh"

module srr_status_regs_asserts
(
  // Clock and reset
  input wire        clk_in,
  input wire        srst_in,
  // Host command port
  input wire        cmd_valid_in,
  input wire [2:0]  cmd_code_in,
  input wire [15:0] cmd_wdata_in,
  input wire        preset_in,
  // Answers and summaries
  input wire        rsp_valid_out,
  input wire [15:0] rsp_data_out,
  input wire        oper_summary_out,
  input wire        ques_summary_out
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // Write codes are 3 and 7, so low bits 11 mark a write
  wire rd_cmd = cmd_valid_in && (cmd_code_in[1:0] != 2'h3);
  // Mask written, one idle cycle, then read back
  property p_back(logic [2:0] wc, logic [2:0] rc);
    (cmd_valid_in && cmd_code_in == wc && !preset_in) ##1 (!cmd_valid_in && !preset_in)
      ##1 (cmd_valid_in && cmd_code_in == rc && !preset_in)
      |=> rsp_data_out == $past(cmd_wdata_in, 3);
  endproperty
  a_read_answers: assert property (rd_cmd |=> rsp_valid_out)
    else $error("read got no answer");
  a_answer_caused: assert property (rsp_valid_out |-> $past(rd_cmd))
    else $error("answer without read");
  a_ques_event_only: assert property (rsp_valid_out && $past(cmd_code_in) == 3'h5
    |-> (rsp_data_out & ~`SRR_QU_LATCH_MASK) == 16'h0000)
    else $error("questionable event outside bits 13 and 12");
  a_oper_unused_zero: assert property (rsp_valid_out && $past(cmd_code_in) < 3'h2
    |-> (rsp_data_out & ~`SRR_OP_USED_MASK) == 16'h0000)
    else $error("operation unused bit set");
  a_ques_unused_zero: assert property (rsp_valid_out && $past(cmd_code_in) == 3'h4
    |-> (rsp_data_out & ~`SRR_QU_USED_MASK) == 16'h0000)
    else $error("questionable unused bit set");
  a_preset_oper: assert property ((preset_in && !cmd_valid_in)
    ##1 (!cmd_valid_in && !preset_in)
    ##1 (cmd_valid_in && cmd_code_in == 3'h2) |=> rsp_data_out == `SRR_OPER_PRESET)
    else $error("preset operation mask wrong");
  a_preset_wins: assert property ((preset_in && cmd_valid_in && cmd_code_in == 3'h7)
    ##1 (!cmd_valid_in && !preset_in) ##1 (cmd_valid_in && cmd_code_in == 3'h6)
    |=> rsp_data_out == `SRR_QUES_PRESET)
    else $error("preset lost to mask write");
  a_oper_readback: assert property (p_back(3'h3, 3'h2))
    else $error("operation mask readback wrong");
  a_ques_readback: assert property (p_back(3'h7, 3'h6))
    else $error("questionable mask readback wrong");
  a_mask_off_quiet: assert property ((cmd_valid_in && cmd_code_in == 3'h3
    && cmd_wdata_in == 16'h0000 && !preset_in)
    ##1 (!preset_in && !(cmd_valid_in && cmd_code_in == 3'h3)) [*2]
    |=> !oper_summary_out)
    else $error("summary set with empty mask");
  c_ques_event: cover property (rsp_valid_out && rsp_data_out[13]);
  c_oper_sum: cover property ($rose(oper_summary_out));
  c_ques_sum: cover property ($rose(ques_summary_out));
endmodule

// [sim/srr_host_model.sv]
// Host model: issues status commands and collects the answers.
// Assumes the bank answers within a few cycles of clk_in.
`timescale 1ns/1ps

module srr_host_model
(
  // Clock
  input  wire        clk_in,
  // Answers from the bank
  input  wire        rsp_valid_in,
  input  wire [15:0] rsp_data_in,
  // Command port, idle from time zero; only the tasks below drive it
  output reg         cmd_valid_out = 1'b0,
  output reg  [2:0]  cmd_code_out  = 3'h0,
  output reg  [15:0] cmd_wdata_out = 16'h0000,
  output reg         preset_out    = 1'b0
);
  // ----------------------------------------------------------------
  // Command tasks
  // ----------------------------------------------------------------
  // Strobes held for one edge; released lines flip so stale data shows
  task wr(input [2:0] c, input [15:0] d, input p, input v);
  begin
    @(posedge clk_in);
    cmd_valid_out <= v;
    cmd_code_out  <= c;
    cmd_wdata_out <= d;
    preset_out    <= p;
    @(posedge clk_in);
    cmd_valid_out <= 1'b0;
    preset_out    <= 1'b0;
    cmd_code_out  <= ~c;
    cmd_wdata_out <= ~d;
  end
  endtask
  // Read with a bounded wait; a missing answer returns unknown
  task rd(input [2:0] c, output [15:0] d);
    integer n;
  begin
    wr(c, 16'h0000, 1'b0, 1'b1);
    #1;
    n = 0;
    while (rsp_valid_in !== 1'b1 && n < 4)
    begin
      @(posedge clk_in);
      #1;
      n = n + 1;
    end
    d = (rsp_valid_in === 1'b1) ? rsp_data_in : 16'hXXXX;
  end
  endtask
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the status register bank.
// Assumes the host model and checker are compiled before this file.
`timescale 1ns/1ps
`include "srr_regs.vh"

module tb_top;
  reg         clk_in      = 1'b0;
  reg         srst_in     = 1'b1;
  reg  [15:0] op_lv       = 16'h0000;
  reg  [15:0] qu_lv       = 16'h0000;
  reg  [31:0] lfsr        = 32'h00011071;
  reg  [15:0] got;
  reg  [15:0] pv;
  reg  [15:0] pq;
  reg  [15:0] e;
  wire        cmd_valid;
  wire        preset;
  wire [2:0]  cmd_code;
  wire [15:0] cmd_wdata;
  wire [15:0] rsp_data;
  wire        rsp_valid;
  wire        oper_sum;
  wire        ques_sum;
  integer     miscompares = 0;
  integer     checks      = 0;
  integer     k;
  // ----------------------------------------------------------------
  // Clock, instances, helpers
  // ----------------------------------------------------------------
  always #5 clk_in = ~clk_in;
  srr_status_regs DUT
  (
    .clk_in(clk_in), .srst_in(srst_in),
    .constant_current_flag_in(op_lv[10]), .constant_voltage_flag_in(op_lv[8]),
    .list_active_flag_in(op_lv[14]), .list_done_flag_in(op_lv[12]),
    .sample_done_flag_in(op_lv[11]), .transient_done_flag_in(op_lv[9]),
    .transient_primed_flag_in(op_lv[6]), .trigger_wait_flag_in(op_lv[5]),
    .energy_absorb_flag_in(qu_lv[14]), .current_fault_flag_in(qu_lv[13]),
    .voltage_fault_flag_in(qu_lv[12]), .follower_unit_fault_flag_in(qu_lv[6]),
    .thermal_fault_flag_in(qu_lv[3]), .current_regulation_fault_flag_in(qu_lv[1]),
    .voltage_regulation_fault_flag_in(qu_lv[0]),
    .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code), .cmd_wdata_in(cmd_wdata),
    .preset_in(preset), .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data),
    .oper_summary_out(oper_sum), .ques_summary_out(ques_sum)
  );
  srr_host_model HOST
  (
    .clk_in(clk_in), .rsp_valid_in(rsp_valid), .rsp_data_in(rsp_data),
    .cmd_valid_out(cmd_valid), .cmd_code_out(cmd_code), .cmd_wdata_out(cmd_wdata),
    .preset_out(preset)
  );
  function [31:0] lfsr_next(input [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task cmp16(input [15:0] g, input [15:0] x);
  begin
    checks = checks + 1;
    if (g !== x)
    begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  end
  endtask
  task cmp1(input g, input x);
    cmp16({15'h0000, g}, {15'h0000, x});
  endtask
  // Settle past the sync and summary stages, then sample off the edge
  task setf(input [15:0] a, input [15:0] b);
  begin
    @(posedge clk_in);
    op_lv <= a;
    qu_lv <= b;
    repeat (5) @(posedge clk_in);
    #1;
  end
  endtask
  task complete_run;
  begin
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  // Watchdog far beyond the under one thousand cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_in);
    miscompares = miscompares + 1;
    complete_run;
  end
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk_in);
    srst_in <= 1'b0;
    for (k = 0; k < 8; k = k + 1)
      if (k[1:0] != 2'h3)
      begin
        HOST.rd(k[2:0], got);
        cmp16(got, 16'h0000);
      end
    $display("test reset done");
    for (k = 0; k < 6; k = k + 1)
    begin
      lfsr = lfsr_next(lfsr);
      HOST.wr(3'h3, (k == 0) ? 16'hFFFF : lfsr[15:0], 1'b0, 1'b1);
      HOST.rd(3'h2, got);
      cmp16(got, (k == 0) ? 16'hFFFF : lfsr[15:0]);
      HOST.wr(3'h7, lfsr[31:16], 1'b0, 1'b1);
      HOST.rd(3'h6, got);
      cmp16(got, lfsr[31:16]);
    end
    HOST.wr(3'h0, 16'h0000, 1'b1, 1'b0);
    HOST.rd(3'h2, got);
    cmp16(got, `SRR_OPER_PRESET);
    HOST.wr(3'h7, 16'h1234, 1'b1, 1'b1);
    HOST.rd(3'h6, got);
    cmp16(got, `SRR_QUES_PRESET);
    $display("test masks done");
    for (k = 0; k < 16; k = k + 1)
    begin
      e = 16'h0001 << k;
      setf(e, e);
      HOST.rd(3'h0, got);
      cmp16(got, e & `SRR_OP_USED_MASK);
      HOST.rd(3'h4, got);
      cmp16(got, e & `SRR_QU_USED_MASK);
      HOST.rd(3'h1, got);
      cmp16(got, e & `SRR_OP_USED_MASK);
      HOST.rd(3'h5, got);
      cmp16(got, e & `SRR_QU_LATCH_MASK);
      HOST.rd(3'h1, got);
      cmp16(got, 16'h0000);
      HOST.rd(3'h5, got);
      cmp16(got, 16'h0000);
      setf(16'h0000, 16'h0000);
      HOST.rd(3'h0, got);
      cmp16(got, 16'h0000);
      HOST.rd(3'h1, got);
      cmp16(got, 16'h0000);
    end
    setf(16'h0000, 16'h0003);
    HOST.rd(3'h4, got);
    cmp16(got, 16'h0003);
    HOST.rd(3'h5, got);
    cmp16(got, 16'h0000);
    $display("test bits done");
    HOST.wr(3'h3, 16'h0400, 1'b0, 1'b1);
    HOST.wr(3'h7, 16'h1000, 1'b0, 1'b1);
    setf(16'h0100, 16'h2000);
    cmp1(oper_sum, 1'b0);
    cmp1(ques_sum, 1'b0);
    setf(16'h0500, 16'h3000);
    cmp1(oper_sum, 1'b1);
    cmp1(ques_sum, 1'b1);
    HOST.rd(3'h1, got);
    HOST.rd(3'h5, got);
    repeat (2) @(posedge clk_in);
    #1;
    cmp1(oper_sum, 1'b0);
    cmp1(ques_sum, 1'b0);
    HOST.wr(3'h3, ~`SRR_OP_USED_MASK, 1'b0, 1'b1);
    HOST.wr(3'h7, ~`SRR_QU_USED_MASK, 1'b0, 1'b1);
    setf(16'h0000, 16'h0000);
    setf(`SRR_OP_USED_MASK, `SRR_QU_USED_MASK);
    cmp1(oper_sum, 1'b0);
    cmp1(ques_sum, 1'b0);
    HOST.wr(3'h3, `SRR_OP_USED_MASK, 1'b0, 1'b1);
    repeat (3) @(posedge clk_in);
    #1;
    cmp1(oper_sum, 1'b1);
    HOST.wr(3'h3, 16'h0000, 1'b0, 1'b1);
    repeat (3) @(posedge clk_in);
    #1;
    cmp1(oper_sum, 1'b0);
    $display("test summaries done");
    setf(16'h0000, 16'h0000);
    HOST.rd(3'h1, got);
    HOST.rd(3'h5, got);
    pv = 16'h0000;
    pq = 16'h0000;
    for (k = 0; k < 20; k = k + 1)
    begin
      lfsr = lfsr_next(lfsr);
      setf(lfsr[15:0], lfsr[31:16]);
      HOST.rd(3'h0, got);
      cmp16(got, lfsr[15:0] & `SRR_OP_USED_MASK);
      HOST.rd(3'h4, got);
      cmp16(got, lfsr[31:16] & `SRR_QU_USED_MASK);
      HOST.rd(3'h1, got);
      cmp16(got, lfsr[15:0] & ~pv & `SRR_OP_USED_MASK);
      HOST.rd(3'h5, got);
      cmp16(got, lfsr[31:16] & ~pq & `SRR_QU_LATCH_MASK);
      pv = lfsr[15:0];
      pq = lfsr[31:16];
    end
    $display("test random done");
    complete_run;
  end
endmodule

bind srr_status_regs srr_status_regs_asserts u_chk
(
  .clk_in(clk_in), .srst_in(srst_in), .cmd_valid_in(cmd_valid_in),
  .cmd_code_in(cmd_code_in), .cmd_wdata_in(cmd_wdata_in), .preset_in(preset_in),
  .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out),
  .oper_summary_out(oper_summary_out), .ques_summary_out(ques_summary_out)
);
